// ===== unk_top.sv
// nak event flags, their masking and control endpoint 0 state registers
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module unk_top (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// axi4-lite register port
	input  wire logic [7:0]  s_axil_awaddr,
	input  wire logic        s_axil_awvalid,
	output logic             s_axil_awready,
	input  wire logic [31:0] s_axil_wdata,
	input  wire logic [3:0]  s_axil_wstrb,
	input  wire logic        s_axil_wvalid,
	output logic             s_axil_wready,
	output logic [1:0]       s_axil_bresp,
	output logic             s_axil_bvalid,
	input  wire logic        s_axil_bready,
	input  wire logic [7:0]  s_axil_araddr,
	input  wire logic        s_axil_arvalid,
	output logic             s_axil_arready,
	output logic [31:0]      s_axil_rdata,
	output logic [1:0]       s_axil_rresp,
	output logic             s_axil_rvalid,
	input  wire logic        s_axil_rready,
	// usb link events, one-cycle pulses
	input  wire logic [7:1]  nak_tx,
	input  wire logic        setup_rx,
	input  wire logic        send_zero_length_cmd,
	input  wire logic        zero_len_sent,
	input  wire logic        ctrl_ep_fifo_loaded,
	input  wire logic        ctrl_ep_fifo_drained,
	// level from the general endpoint event mask register
	input  wire logic [7:1]  endpoint_event_mask,
	// results
	output logic             nak_event,
	output logic [6:0]       ctrl_ep_max_packet_size,
	output logic             zero_len_send_pending,
	output logic             ctrl_ep_fifo_valid,
	output logic             irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:1] nak_mask;
		logic [6:0] max_pkt_size;
		logic       zlp_pend;
		logic       fifo_valid;
		logic [2:0] irq_stat;
		logic [2:0] irq_en;
		logic       nak_out;
		logic       irq_out;
	} unk_top_s;

	unk_top_s    st;
	unk_top_s    next_st;
	logic [7:1]  flags;
	logic [7:1]  flag_clr;
	logic [7:1]  nak_pass;
	logic        wr_flags;
	logic        wr_mask;
	logic        wr_maxpkt;
	logic        wr_irq_clr;
	logic        wr_irq_en;
	logic [2:0]  irq_evt;
	logic [31:0] rd_word;

	unk_regs_if rif ();

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// true for every offset that the register file answers
	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == unk_pkg::OFS_NAK_FLAGS) || (a == unk_pkg::OFS_NAK_MASK)
			|| (a == unk_pkg::OFS_MAX_PKT) || (a == unk_pkg::OFS_IRQ_STAT)
			|| (a == unk_pkg::OFS_IRQ_CLR) || (a == unk_pkg::OFS_IRQ_EN);
	endfunction : addr_known

	// write strobe for one offset, low byte lane enabled
	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = rif.wr_en && (rif.wr_addr == ofs) && rif.wr_strb[0];
	endfunction : wr_hit

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	unk_axil_slave u_slave (
		.sys_clk        (sys_clk),
		.rst_b          (rst_b),
		.s_axil_awaddr  (s_axil_awaddr),
		.s_axil_awvalid (s_axil_awvalid),
		.s_axil_awready (s_axil_awready),
		.s_axil_wdata   (s_axil_wdata),
		.s_axil_wstrb   (s_axil_wstrb),
		.s_axil_wvalid  (s_axil_wvalid),
		.s_axil_wready  (s_axil_wready),
		.s_axil_bresp   (s_axil_bresp),
		.s_axil_bvalid  (s_axil_bvalid),
		.s_axil_bready  (s_axil_bready),
		.s_axil_araddr  (s_axil_araddr),
		.s_axil_arvalid (s_axil_arvalid),
		.s_axil_arready (s_axil_arready),
		.s_axil_rdata   (s_axil_rdata),
		.s_axil_rresp   (s_axil_rresp),
		.s_axil_rvalid  (s_axil_rvalid),
		.s_axil_rready  (s_axil_rready),
		.rif            (rif.slave)
	);

	// write strobes per register
	assign wr_flags   = wr_hit(unk_pkg::OFS_NAK_FLAGS);
	assign wr_mask    = wr_hit(unk_pkg::OFS_NAK_MASK);
	assign wr_maxpkt  = wr_hit(unk_pkg::OFS_MAX_PKT);
	assign wr_irq_clr = wr_hit(unk_pkg::OFS_IRQ_CLR);
	assign wr_irq_en  = wr_hit(unk_pkg::OFS_IRQ_EN);
	assign rif.wr_ok  = addr_known(rif.wr_addr);
	assign rif.rd_ok  = addr_known(rif.rd_addr);

	// ----------------------------------------------------------------
	// nak flags
	// ----------------------------------------------------------------
	// ones written to the flag register clear those flags
	assign flag_clr = wr_flags ? rif.wr_data[7:1] : '0;

	unk_nak_flags u_flags (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.nak_tx  (nak_tx),
		.clr     (flag_clr),
		.flags   (flags)
	);

	// a flag passes only when neither mask holds it back
	assign nak_pass = flags & ~st.nak_mask & ~endpoint_event_mask;

	// ----------------------------------------------------------------
	// interrupt events
	// ----------------------------------------------------------------
	assign irq_evt[unk_pkg::IRQ_NAK]   = |nak_tx;
	assign irq_evt[unk_pkg::IRQ_SETUP] = setup_rx;
	assign irq_evt[unk_pkg::IRQ_ZLP]   = zero_len_sent;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// reserved and unused bits read as zero
	always_comb
	begin
		rd_word = '0;
		unique case (rif.rd_addr)
			unk_pkg::OFS_NAK_FLAGS:
				rd_word[7:1] = flags;
			unk_pkg::OFS_NAK_MASK:
				rd_word[7:1] = st.nak_mask;
			unk_pkg::OFS_MAX_PKT:
			begin
				rd_word[unk_pkg::ZLP_BIT]      = st.zlp_pend;
				rd_word[unk_pkg::FIFO_VLD_BIT] = st.fifo_valid;
				rd_word[6:0]                   = st.max_pkt_size;
			end
			unk_pkg::OFS_IRQ_STAT:
				rd_word[2:0] = st.irq_stat;
			unk_pkg::OFS_IRQ_EN:
				rd_word[2:0] = st.irq_en;
			default:
				rd_word = '0; // clear register and unmapped
		endcase
	end
	assign rif.rd_data = rd_word;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		// software-owned fields
		if (wr_mask)
			next_st.nak_mask = rif.wr_data[7:1];
		if (wr_maxpkt)
			next_st.max_pkt_size = rif.wr_data[6:0];
		if (wr_irq_en)
			next_st.irq_en = rif.wr_data[2:0];
		// pending zero-length send: a new command beats completion
		if (zero_len_sent)
			next_st.zlp_pend = 1'b0;
		if (send_zero_length_cmd)
			next_st.zlp_pend = 1'b1;
		// fifo valid: setup token overrides everything
		if (ctrl_ep_fifo_drained)
			next_st.fifo_valid = 1'b0;
		if (ctrl_ep_fifo_loaded)
			next_st.fifo_valid = 1'b1;
		if (setup_rx)
			next_st.fifo_valid = 1'b0;
		// sticky status: set wins over a clear in the same cycle
		if (wr_irq_clr)
			next_st.irq_stat = st.irq_stat & ~rif.wr_data[2:0];
		next_st.irq_stat = next_st.irq_stat | irq_evt;
		// registered outputs
		next_st.nak_out = |nak_pass;
		next_st.irq_out = |(st.irq_stat & st.irq_en);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			st              <= '0;
			st.max_pkt_size <= unk_pkg::RST_MAX_PKT;
		end
		else
			st <= next_st;
	end

	// outputs straight from flops
	assign nak_event               = st.nak_out;
	assign ctrl_ep_max_packet_size = st.max_pkt_size;
	assign zero_len_send_pending   = st.zlp_pend;
	assign ctrl_ep_fifo_valid      = st.fifo_valid;
	assign irq                     = st.irq_out;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	// a nak on any endpoint sets its flag one edge later
	a_flag_on_nak: assert property (
		(nak_tx != '0) |=> ((flags & $past(nak_tx)) == $past(nak_tx)))
		else $error("nak did not set its flag");

	// nak mask alone blocks every set flag
	a_nakmask_blocks: assert property (
		(flags != '0 && endpoint_event_mask == '0 && (flags & ~st.nak_mask) == '0)
		|=> !nak_event)
		else $error("nak mask did not block output");

	// masked endpoints still record their nak
	a_masked_flag_set: assert property (
		((nak_tx & st.nak_mask) != '0)
		|=> ((flags & $past(nak_tx & st.nak_mask)) == $past(nak_tx & st.nak_mask)))
		else $error("masked nak lost its flag");

	// endpoint event mask alone blocks every set flag
	a_epmask_blocks: assert property (
		(flags != '0 && st.nak_mask == '0 && (flags & ~endpoint_event_mask) == '0)
		|=> !nak_event)
		else $error("endpoint mask did not block output");

	// output follows the gated flags with one cycle of latency
	a_nak_out_gate: assert property (
		##1 (nak_event == $past(|(flags & ~st.nak_mask & ~endpoint_event_mask))))
		else $error("nak output does not match gated flags");

	// writing ones clears those flags when no nak races it
	a_w1c_clear: assert property (
		(flag_clr != '0 && nak_tx == '0) |=> ((flags & $past(flag_clr)) == '0))
		else $error("write of one did not clear flag");

	// pending zero-length send rises after the command
	a_zlp_set: assert property (
		send_zero_length_cmd |=> zero_len_send_pending)
		else $error("zero-length pending not set");

	// and falls once the packet has gone out
	a_zlp_clear: assert property (
		(zero_len_sent && !send_zero_length_cmd) |=> !zero_len_send_pending)
		else $error("zero-length pending not cleared");

	// fifo valid follows a load and holds until drained
	a_fifo_valid: assert property (
		(ctrl_ep_fifo_loaded && !setup_rx) ##1 (!ctrl_ep_fifo_drained && !setup_rx) [*2]
		|-> ctrl_ep_fifo_valid [*2])
		else $error("fifo valid not held after load");

	// setup token forces fifo valid low even against a load
	a_setup_clears: assert property (
		setup_rx |=> !ctrl_ep_fifo_valid)
		else $error("setup did not clear fifo valid");

	// written packet size appears on the limit output
	a_max_pkt_write: assert property (
		wr_maxpkt |=> (ctrl_ep_max_packet_size == $past(rif.wr_data[6:0])))
		else $error("max packet size not updated");

	// each nak, setup and zero-length-sent event lands in its sticky status bit
	a_irq_stat_set: assert property (
		(irq_evt != '0) |=> ((st.irq_stat & $past(irq_evt)) == $past(irq_evt)))
		else $error("event did not set its status bit");

	// interrupt line follows enabled status bits
	a_irq_level: assert property (
		(irq_evt == '0 && !wr_irq_clr && !wr_irq_en) ##1 1'b1
		|=> (irq == |($past(st.irq_stat & st.irq_en))))
		else $error("interrupt level wrong");
endmodule : unk_top

// ===== unk_pkg.sv
// shared constants for the nak event and control endpoint register block
package unk_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam logic [7:0]  OFS_NAK_FLAGS = 8'h00;
	localparam logic [7:0]  OFS_NAK_MASK  = 8'h04;
	localparam logic [7:0]  OFS_MAX_PKT   = 8'h08;
	localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0c;
	localparam logic [7:0]  OFS_IRQ_CLR   = 8'h10;
	localparam logic [7:0]  OFS_IRQ_EN    = 8'h14;
	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int          EP_LO         = 1;
	localparam int          EP_HI         = 7;
	localparam int          ZLP_BIT       = 15;
	localparam int          FIFO_VLD_BIT  = 12;
	localparam int          MAX_PKT_W     = 7;
	localparam int          IRQ_NAK       = 0;
	localparam int          IRQ_SETUP     = 1;
	localparam int          IRQ_ZLP       = 2;
	localparam int          IRQ_W         = 3;
	// ----------------------------------------------------------------
	// reset values and bus responses
	// ----------------------------------------------------------------
	localparam logic [6:0]  RST_MAX_PKT   = 7'h00;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : unk_pkg

// ===== unk_regs_if.sv
// register access strobes between the bus slave and the register file
`timescale 1ns/1ps
interface unk_regs_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_ok;
	logic        rd_en;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_ok;
	modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_ok, rd_data, rd_ok);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_ok, rd_data, rd_ok);
endinterface : unk_regs_if

// ===== unk_nak_flags.sv
// sticky per-endpoint nak flags with write-one-to-clear
`timescale 1ns/1ps
module unk_nak_flags (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic [7:1] nak_tx,
	input  wire logic [7:1] clr,
	output logic      [7:1] flags
);
	typedef struct packed {
		logic [7:1] flag;
	} unk_nak_s;
	unk_nak_s   st;
	unk_nak_s   next_st;
	logic [7:1] next_bit;
	// ----------------------------------------------------------------
	// one flag per endpoint; a nak in the clearing cycle wins
	// ----------------------------------------------------------------
	for (genvar e = unk_pkg::EP_LO; e <= unk_pkg::EP_HI; e++)
	begin : g_ep
		assign next_bit[e] = nak_tx[e] | (st.flag[e] & ~clr[e]);
	end
	// next state
	always_comb
	begin
		next_st      = st;
		next_st.flag = next_bit;
	end
	// state register
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end
	assign flags = st.flag;
endmodule : unk_nak_flags

// ===== unk_axil_slave.sv
// axi4-lite slave front end turning bus beats into register strobes
`timescale 1ns/1ps
module unk_axil_slave (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  s_axil_awaddr,
	input  wire logic        s_axil_awvalid,
	output logic             s_axil_awready,
	input  wire logic [31:0] s_axil_wdata,
	input  wire logic [3:0]  s_axil_wstrb,
	input  wire logic        s_axil_wvalid,
	output logic             s_axil_wready,
	output logic [1:0]       s_axil_bresp,
	output logic             s_axil_bvalid,
	input  wire logic        s_axil_bready,
	input  wire logic [7:0]  s_axil_araddr,
	input  wire logic        s_axil_arvalid,
	output logic             s_axil_arready,
	output logic [31:0]      s_axil_rdata,
	output logic [1:0]       s_axil_rresp,
	output logic             s_axil_rvalid,
	input  wire logic        s_axil_rready,
	unk_regs_if.slave        rif
);
	typedef struct packed {
		logic        aw_held;
		logic        w_held;
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
		logic        aw_rdy;
		logic        w_rdy;
		logic        ar_rdy;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} unk_axi_s;
	unk_axi_s st;
	unk_axi_s next_st;
	// register strobes: write once address and data are both held
	assign rif.wr_en   = st.aw_held & st.w_held & ~st.bvalid;
	assign rif.wr_addr = st.addr;
	assign rif.wr_data = st.data;
	assign rif.wr_strb = st.strb;
	assign rif.rd_en   = s_axil_arvalid & st.ar_rdy;
	assign rif.rd_addr = s_axil_araddr;
	// channel bookkeeping; readies are registered copies of free slots
	always_comb
	begin
		next_st = st;
		if (s_axil_awvalid && st.aw_rdy)
		begin
			next_st.aw_held = 1'b1;
			next_st.addr    = s_axil_awaddr;
		end
		if (s_axil_wvalid && st.w_rdy)
		begin
			next_st.w_held = 1'b1;
			next_st.data   = s_axil_wdata;
			next_st.strb   = s_axil_wstrb;
		end
		if (st.bvalid && s_axil_bready)
			next_st.bvalid = 1'b0;
		if (rif.wr_en)
		begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = rif.wr_ok ? unk_pkg::RESP_OKAY : unk_pkg::RESP_SLVERR;
		end
		if (st.rvalid && s_axil_rready)
			next_st.rvalid = 1'b0;
		if (rif.rd_en)
		begin
			next_st.rvalid = 1'b1;
			next_st.rdata  = rif.rd_ok ? rif.rd_data : '0;
			next_st.rresp  = rif.rd_ok ? unk_pkg::RESP_OKAY : unk_pkg::RESP_SLVERR;
		end
		next_st.aw_rdy = ~next_st.aw_held & ~next_st.bvalid;
		next_st.w_rdy  = ~next_st.w_held & ~next_st.bvalid;
		next_st.ar_rdy = ~next_st.rvalid;
	end
	// state register
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end
	assign s_axil_awready = st.aw_rdy;
	assign s_axil_wready  = st.w_rdy;
	assign s_axil_bvalid  = st.bvalid;
	assign s_axil_bresp   = st.bresp;
	assign s_axil_arready = st.ar_rdy;
	assign s_axil_rvalid  = st.rvalid;
	assign s_axil_rdata   = st.rdata;
	assign s_axil_rresp   = st.rresp;
endmodule : unk_axil_slave

// ===== unk_usb_host_model.sv
// usb host side model that raises link event pulses toward the block
`timescale 1ns/1ps
module unk_usb_host_model (
	input  wire logic       sys_clk,
	output logic      [7:1] nak_tx,
	output logic            setup_rx,
	output logic            send_zero_length_cmd,
	output logic            zero_len_sent,
	output logic            ctrl_ep_fifo_loaded,
	output logic            ctrl_ep_fifo_drained
);
	// ----------------------------------------------------------------
	// link activity
	// ----------------------------------------------------------------
	// every event line rests low between pulses
	initial
	begin
		nak_tx = 7'h00;
		{setup_rx, send_zero_length_cmd, zero_len_sent} = 3'h0;
		{ctrl_ep_fifo_loaded, ctrl_ep_fifo_drained} = 2'h0;
	end

	// one-cycle pulse after an idle gap; ev is setup, zl cmd, zl sent, loaded, drained
	task automatic send(input int gap, input logic [7:1] ep, input logic [4:0] ev);
		repeat (gap) @(posedge sys_clk);
		@(posedge sys_clk);
		nak_tx <= ep;
		{setup_rx, send_zero_length_cmd, zero_len_sent} <= ev[4:2];
		{ctrl_ep_fifo_loaded, ctrl_ep_fifo_drained} <= ev[1:0];
		@(posedge sys_clk);
		nak_tx <= 7'h00;
		{setup_rx, send_zero_length_cmd, zero_len_sent} <= 3'h0;
		{ctrl_ep_fifo_loaded, ctrl_ep_fifo_drained} <= 2'h0;
	endtask : send
endmodule : unk_usb_host_model

// ===== usb_nak_event_ep0_size_bench.sv
// self-checking bench for the nak event and control endpoint register block
`timescale 1ns/1ps
module usb_nak_event_ep0_size_bench;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam logic [4:0]  EV_SETUP = 5'h10;
	localparam logic [4:0]  EV_ZCMD  = 5'h08;
	localparam logic [4:0]  EV_ZSENT = 5'h04;
	localparam logic [4:0]  EV_LOAD  = 5'h02;
	localparam logic [4:0]  EV_DRAIN = 5'h01;
	localparam logic [31:0] O_NAK    = 32'h001;
	localparam logic [31:0] O_SIZE   = 32'h0fe;
	localparam logic [31:0] O_ZLP    = 32'h100;
	localparam logic [31:0] O_FIFO   = 32'h200;
	localparam logic [31:0] O_IRQ    = 32'h400;
	logic        sys_clk, rst_b;
	logic [7:0]  s_axil_awaddr, s_axil_araddr;
	logic        s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
	logic [31:0] s_axil_wdata, s_axil_rdata;
	logic [3:0]  s_axil_wstrb;
	logic [1:0]  s_axil_bresp, s_axil_rresp;
	logic        s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
	logic        s_axil_rvalid, s_axil_rready;
	logic [7:1]  nak_tx, endpoint_event_mask;
	logic        setup_rx, send_zero_length_cmd, zero_len_sent;
	logic        ctrl_ep_fifo_loaded, ctrl_ep_fifo_drained;
	logic        nak_event, zero_len_send_pending, ctrl_ep_fifo_valid, irq;
	logic [6:0]  ctrl_ep_max_packet_size;
	logic [31:0] rd;
	int          bad_count, total_checks, cycles;

	// ----------------------------------------------------------------
	// instances
	// ----------------------------------------------------------------
	unk_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .s_axil_awaddr(s_axil_awaddr),
		.s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
		.s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb),
		.s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
		.s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid),
		.s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr),
		.s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
		.s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp),
		.s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
		.nak_tx(nak_tx), .setup_rx(setup_rx), .send_zero_length_cmd(send_zero_length_cmd),
		.zero_len_sent(zero_len_sent), .ctrl_ep_fifo_loaded(ctrl_ep_fifo_loaded),
		.ctrl_ep_fifo_drained(ctrl_ep_fifo_drained),
		.endpoint_event_mask(endpoint_event_mask), .nak_event(nak_event),
		.ctrl_ep_max_packet_size(ctrl_ep_max_packet_size),
		.zero_len_send_pending(zero_len_send_pending),
		.ctrl_ep_fifo_valid(ctrl_ep_fifo_valid), .irq(irq));

	unk_usb_host_model host (.sys_clk(sys_clk), .nak_tx(nak_tx), .setup_rx(setup_rx),
		.send_zero_length_cmd(send_zero_length_cmd), .zero_len_sent(zero_len_sent),
		.ctrl_ep_fifo_loaded(ctrl_ep_fifo_loaded),
		.ctrl_ep_fifo_drained(ctrl_ep_fifo_drained));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// clock at 100 mhz
	initial
	begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	// verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	// bus write; address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
		@(posedge sys_clk);
		s_axil_awaddr  <= a;
		s_axil_awvalid <= 1'h1;
		s_axil_wdata   <= d;
		s_axil_wvalid  <= 1'h1;
		s_axil_bready  <= 1'h1;
		do
		begin
			@(posedge sys_clk);
			if (s_axil_awready === 1'h1) s_axil_awvalid <= 1'h0;
			if (s_axil_wready === 1'h1) s_axil_wvalid <= 1'h0;
		end
		while (s_axil_bvalid !== 1'h1);
		s_axil_bready <= 1'h0;
		check({30'h0, s_axil_bresp}, {30'h0, exp}, "write response");
	endtask : wr

	// bus read returning data and checking the response code
	task automatic rd_reg(input logic [7:0] a, input logic [1:0] exp, output logic [31:0] d);
		@(posedge sys_clk);
		s_axil_araddr  <= a;
		s_axil_arvalid <= 1'h1;
		s_axil_rready  <= 1'h1;
		do
		begin
			@(posedge sys_clk);
			if (s_axil_arready === 1'h1) s_axil_arvalid <= 1'h0;
		end
		while (s_axil_rvalid !== 1'h1);
		s_axil_rready <= 1'h0;
		d = s_axil_rdata;
		check({30'h0, s_axil_rresp}, {30'h0, exp}, "read response");
	endtask : rd_reg

	// read a mapped register and compare its word
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd_reg(a, unk_pkg::RESP_OKAY, d);
		check(d, exp, "register word");
	endtask : rchk

	// let event latency pass, then compare selected block outputs
	task automatic ochk(input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] o;
		repeat (2) @(posedge sys_clk);
		o = {21'h0, irq, ctrl_ep_fifo_valid, zero_len_send_pending, ctrl_ep_max_packet_size,
			nak_event};
		check(o & mask, exp, "block outputs");
	endtask : ochk

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// register values straight after reset
	task automatic t_reset();
		rchk(unk_pkg::OFS_NAK_FLAGS, 32'h0);
		rchk(unk_pkg::OFS_NAK_MASK, 32'h0);
		rchk(unk_pkg::OFS_MAX_PKT, 32'h0);
		ochk(O_NAK | O_SIZE | O_ZLP | O_FIFO | O_IRQ, 32'h0);
		$display("test reset done");
	endtask : t_reset

	// every endpoint: masked flag sets silently, unmask raises output, w1c clears
	task automatic t_nak_each_ep();
		logic [7:1] m;
		for (int ep = 1; ep <= 7; ep++)
		begin
			m = 7'h01 << (ep - 1);
			wr(unk_pkg::OFS_NAK_MASK, {24'h0, m, 1'h0}, unk_pkg::RESP_OKAY);
			host.send(ep % 3, m, 5'h00);
			rchk(unk_pkg::OFS_NAK_FLAGS, {24'h0, m, 1'h0});
			ochk(O_NAK, 32'h0);
			wr(unk_pkg::OFS_NAK_MASK, 32'h0, unk_pkg::RESP_OKAY);
			ochk(O_NAK, O_NAK);
			wr(unk_pkg::OFS_NAK_FLAGS, {24'h0, m, 1'h0}, unk_pkg::RESP_OKAY);
			rchk(unk_pkg::OFS_NAK_FLAGS, 32'h0);
			ochk(O_NAK, 32'h0);
		end
		$display("test nak per endpoint done");
	endtask : t_nak_each_ep

	// two naks one idle cycle apart, zero writes, endpoint event mask gating, reserved bits
	task automatic t_nak_gating();
		host.send(0, 7'h04, 5'h00);
		host.send(0, 7'h40, 5'h00);
		wr(unk_pkg::OFS_NAK_FLAGS, 32'h0, unk_pkg::RESP_OKAY);
		rchk(unk_pkg::OFS_NAK_FLAGS, 32'h88);
		@(posedge sys_clk);
		endpoint_event_mask <= 7'h44;
		ochk(O_NAK, 32'h0);
		endpoint_event_mask <= 7'h04;
		ochk(O_NAK, O_NAK);
		wr(unk_pkg::OFS_NAK_FLAGS, 32'h08, unk_pkg::RESP_OKAY);
		rchk(unk_pkg::OFS_NAK_FLAGS, 32'h80);
		wr(unk_pkg::OFS_NAK_FLAGS, 32'h80, unk_pkg::RESP_OKAY);
		ochk(O_NAK, 32'h0);
		endpoint_event_mask <= 7'h00;
		wr(unk_pkg::OFS_NAK_MASK, 32'hffffffff, unk_pkg::RESP_OKAY);
		rchk(unk_pkg::OFS_NAK_MASK, 32'hfe);
		wr(unk_pkg::OFS_NAK_MASK, 32'h0, unk_pkg::RESP_OKAY);
		$display("test nak gating done");
	endtask : t_nak_gating

	// zero-length send pending, including command and sent in one cycle
	task automatic t_zero_len();
		host.send(0, 7'h00, EV_ZCMD);
		rchk(unk_pkg::OFS_MAX_PKT, 32'h8000);
		ochk(O_ZLP, O_ZLP);
		host.send(4, 7'h00, EV_ZSENT);
		rchk(unk_pkg::OFS_MAX_PKT, 32'h0);
		host.send(0, 7'h00, EV_ZCMD | EV_ZSENT);
		rchk(unk_pkg::OFS_MAX_PKT, 32'h8000);
		host.send(0, 7'h00, EV_ZSENT);
		ochk(O_ZLP, 32'h0);
		$display("test zero length done");
	endtask : t_zero_len

	// fifo valid flag set, drained and forced low by setup
	task automatic t_fifo();
		host.send(0, 7'h00, EV_LOAD);
		rchk(unk_pkg::OFS_MAX_PKT, 32'h1000);
		ochk(O_FIFO, O_FIFO);
		host.send(0, 7'h00, EV_SETUP);
		rchk(unk_pkg::OFS_MAX_PKT, 32'h0);
		host.send(0, 7'h00, EV_SETUP | EV_LOAD);
		ochk(O_FIFO, 32'h0);
		host.send(0, 7'h00, EV_LOAD);
		host.send(0, 7'h00, EV_DRAIN);
		rchk(unk_pkg::OFS_MAX_PKT, 32'h0);
		$display("test fifo valid done");
	endtask : t_fifo

	// packet size field is seven bits wide and drives the size output
	task automatic t_max_pkt();
		wr(unk_pkg::OFS_MAX_PKT, 32'hffffffff, unk_pkg::RESP_OKAY);
		rchk(unk_pkg::OFS_MAX_PKT, 32'h7f);
		ochk(O_SIZE, 32'hfe);
		wr(unk_pkg::OFS_MAX_PKT, 32'h55, unk_pkg::RESP_OKAY);
		rchk(unk_pkg::OFS_MAX_PKT, 32'h55);
		ochk(O_SIZE, 32'haa);
		$display("test max packet done");
	endtask : t_max_pkt

	// interrupt raise, mask, clear, and unmapped accesses
	task automatic t_irq();
		wr(unk_pkg::OFS_IRQ_CLR, 32'h7, unk_pkg::RESP_OKAY);
		wr(unk_pkg::OFS_IRQ_EN, 32'h7, unk_pkg::RESP_OKAY);
		host.send(0, 7'h01, 5'h00);
		rchk(unk_pkg::OFS_IRQ_STAT, 32'h1);
		ochk(O_IRQ, O_IRQ);
		wr(unk_pkg::OFS_IRQ_CLR, 32'h1, unk_pkg::RESP_OKAY);
		wr(unk_pkg::OFS_NAK_FLAGS, 32'h02, unk_pkg::RESP_OKAY);
		ochk(O_IRQ | O_NAK, 32'h0);
		wr(unk_pkg::OFS_IRQ_EN, 32'h0, unk_pkg::RESP_OKAY);
		host.send(0, 7'h00, EV_SETUP | EV_ZSENT);
		wr(unk_pkg::OFS_IRQ_STAT, 32'h7, unk_pkg::RESP_OKAY);
		rchk(unk_pkg::OFS_IRQ_STAT, 32'h6);
		ochk(O_IRQ, 32'h0);
		wr(unk_pkg::OFS_IRQ_EN, 32'h2, unk_pkg::RESP_OKAY);
		ochk(O_IRQ, O_IRQ);
		wr(unk_pkg::OFS_IRQ_CLR, 32'h6, unk_pkg::RESP_OKAY);
		rchk(unk_pkg::OFS_IRQ_STAT, 32'h0);
		ochk(O_IRQ, 32'h0);
		wr(8'hfc, 32'h1, unk_pkg::RESP_SLVERR);
		rd_reg(8'hfc, unk_pkg::RESP_SLVERR, rd);
		check(rd, 32'h0, "unmapped read data");
		$display("test interrupt done");
	endtask : t_irq

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	// hang guard well above the expected few hundred cycles
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			$display("[ERR] %0t run timed out", $time);
			stop_test();
		end
	end

	// reset, then each scenario in turn
	initial
	begin
		{bad_count, total_checks, cycles} = '0;
		rst_b = 1'h0;
		{s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
		{s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
		s_axil_wstrb = 4'hf;
		endpoint_event_mask = 7'h00;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'h1;
		t_reset();
		t_nak_each_ep();
		t_nak_gating();
		t_zero_len();
		t_fifo();
		t_max_pkt();
		t_irq();
		stop_test();
	end
endmodule : usb_nak_event_ep0_size_bench
